/* File: rtl/ptws_pkg.sv */
// package for the target window sizer: register map, reset values, field positions
// assumes a 32-bit axi4-lite register bus and one 200 MHz clock
package ptws_pkg;
	localparam logic [31:0] IO_SIZE_OFFSET = 32'hfffed120;
	localparam logic [31:0] MEM_SIZE_OFFSET = 32'hfffed124;
	localparam logic [31:0] STATUS_OFFSET = 32'hfffed12c;
	localparam logic [31:0] INT_MASK_OFFSET = 32'hfffed130;
	localparam logic [31:0] IO_SIZE_RESET = 32'hff000000;
	localparam logic [31:0] MEM_SIZE_RESET = 32'h80000000;
	localparam int IO_SIZE_LSB = 2;
	localparam int MEM_SIZE_LSB = 4;
	localparam int ILLEGAL_SIZE_BIT = 2;
	localparam logic [31:0] STATUS_RESET = 32'h00000000;
	localparam logic [31:0] INT_MASK_RESET = 32'h00000000;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : ptws_pkg

/* File: rtl/ptws_size_check.sv */
// size check: a value is legal when it is all zero or ones from bit 31 down then zeros
// assumes the caller has already cleared the bits below the field's low bit
`timescale 1ns/1ps
`default_nettype none
module ptws_size_check #(
	parameter int LSB = 2
) (
	input wire logic [31:0] sizeValue,
	output logic legal,
	output logic disabled
);
	// refused at elaboration: a field low bit outside the word cannot be served
	if (LSB < 0 || LSB > 31) begin : g_bad_lsb
		$error("ptws_size_check: LSB out of range");
	end
	// contiguous ones from the top: inverted value plus one is a power of two or zero
	wire logic [31:0] inverted = ~sizeValue;
	wire logic [31:0] plusOne = inverted + 32'h00000001;
	wire logic contiguous = ((plusOne & inverted) == 32'h00000000);
	assign disabled = (sizeValue == 32'h00000000);
	assign legal = disabled || contiguous;
endmodule : ptws_size_check
`default_nettype wire

/* File: rtl/ptws_base_mask.sv */
// base register sizing view: the ones a pci master would read back after writing all ones
// assumes the size register already holds its field bits only
`timescale 1ns/1ps
`default_nettype none
module ptws_base_mask (
	input wire logic [31:0] sizeValue,
	input wire logic [31:0] baseWritten,
	input wire logic [31:0] mapWritten,
	output logic [31:0] baseMasked,
	output logic [31:0] mapMasked
);
	assign baseMasked = baseWritten & sizeValue;
	assign mapMasked = mapWritten & sizeValue;
endmodule : ptws_base_mask
`default_nettype wire

/* File: rtl/ptws_window_sizer.sv */
// target window sizer: two inbound window size registers behind an axi4-lite slave
// assumes the bridge supplies clk and rst_n; pci base and map registers live outside
// Operation
// - size registers sit on the local bus only, never in pci config space
// - all-zero io size disables the io window
// - io size resets to ff000000, a 16 megabyte window
// - io size bits 31:2 mask io base and io local map address
// - all-ones written io base reads back masked by io size
// - io size is ones from bit 31 down, 4 bytes to 2 gigabytes
// - non power-of-two size sets illegal-size flag, interrupt when enabled
// - all-zero memory size disables the memory window
// - memory size resets to 80000000, a 2 gigabyte window
// - memory size bits 31:4 mask memory base and local map address
// - all-ones written memory base reads back masked by memory size
// - memory size is ones from bit 31 down and zeros below
// - illegal-size flag is status bit 2, shared, resets to zero
//
// The implementer's own choice: the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
module ptws_window_sizer (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [31:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [31:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [31:0] ioBaseAddr,
	input wire logic [31:0] ioLocalMapAddr,
	input wire logic [31:0] memBaseAddr,
	input wire logic [31:0] memLocalMapAddr,
	output logic [31:0] ioBaseReadback,
	output logic [31:0] ioLocalMapMasked,
	output logic [31:0] memBaseReadback,
	output logic [31:0] memLocalMapMasked,
	output logic ioWindowEnable,
	output logic memWindowEnable,
	output logic irq
);
	// reset release through two flip-flops
	logic rstSync1;
	logic rstSync2;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rstSync1 <= 1'b0;
			rstSync2 <= 1'b0;
		end else begin
			rstSync1 <= 1'b1;
			rstSync2 <= rstSync1;
		end
	end
	wire logic rstLocal_n = rstSync2;

	function automatic logic [31:0] ptws_strobe(input logic [31:0] oldV, input logic [31:0] newV,
		input logic [3:0] strb, input logic [31:0] fieldMask);
		logic [31:0] merged;
		merged = oldV;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				merged[i*8 +: 8] = newV[i*8 +: 8];
			end
		end
		return merged & fieldMask;
	endfunction : ptws_strobe

	localparam logic [31:0] IO_FIELD = ~((32'h00000001 << ptws_pkg::IO_SIZE_LSB) - 32'h00000001);
	localparam logic [31:0] MEM_FIELD = ~((32'h00000001 << ptws_pkg::MEM_SIZE_LSB) - 32'h00000001);
	localparam logic [31:0] FLAG_MASK = 32'h00000001 << ptws_pkg::ILLEGAL_SIZE_BIT;

	logic [31:0] ioSize;
	logic [31:0] memSize;
	logic [31:0] status;
	logic [31:0] intMask;

	// write channel: address and data held until both arrive
	logic awHeld;
	logic wHeld;
	logic [31:0] awAddr;
	logic [31:0] wData;
	logic [3:0] wStrb;
	wire logic awTake = s_axi_awvalid && s_axi_awready;
	wire logic wTake = s_axi_wvalid && s_axi_wready;
	wire logic haveAw = awHeld || awTake;
	wire logic haveW = wHeld || wTake;
	wire logic [31:0] curAwAddr = awHeld ? awAddr : s_axi_awaddr;
	wire logic [31:0] curWData = wHeld ? wData : s_axi_wdata;
	wire logic [3:0] curWStrb = wHeld ? wStrb : s_axi_wstrb;
	wire logic doWrite = haveAw && haveW && !s_axi_bvalid;

	// register decode on the local bus address only; no pci config path reaches it
	wire logic wrIo = doWrite && (curAwAddr == ptws_pkg::IO_SIZE_OFFSET);
	wire logic wrMem = doWrite && (curAwAddr == ptws_pkg::MEM_SIZE_OFFSET);
	wire logic wrMask = doWrite && (curAwAddr == ptws_pkg::INT_MASK_OFFSET);
	wire logic wrStatus = doWrite && (curAwAddr == ptws_pkg::STATUS_OFFSET);
	wire logic wrHit = wrIo || wrMem || wrMask || wrStatus;

	wire logic [31:0] next_ioSize = ptws_strobe(ioSize, curWData, curWStrb, IO_FIELD);
	wire logic [31:0] next_memSize = ptws_strobe(memSize, curWData, curWStrb, MEM_FIELD);
	wire logic [31:0] next_intMask = ptws_strobe(intMask, curWData, curWStrb, FLAG_MASK);

	// check the value being written, not the stored one, so the flag lands with the write
	wire logic ioNewLegal;
	wire logic memNewLegal;
	ptws_size_check #(.LSB(ptws_pkg::IO_SIZE_LSB)) ioCheck (
		.sizeValue(next_ioSize),
		.legal(ioNewLegal),
		.disabled()
	);
	ptws_size_check #(.LSB(ptws_pkg::MEM_SIZE_LSB)) memCheck (
		.sizeValue(next_memSize),
		.legal(memNewLegal),
		.disabled()
	);
	wire logic sizeBad = (wrIo && !ioNewLegal) || (wrMem && !memNewLegal);

	// read channel
	wire logic arTake = s_axi_arvalid && s_axi_arready;
	wire logic rdStatus = arTake && (s_axi_araddr == ptws_pkg::STATUS_OFFSET);
	wire logic rdHit = (s_axi_araddr == ptws_pkg::IO_SIZE_OFFSET) ||
		(s_axi_araddr == ptws_pkg::MEM_SIZE_OFFSET) ||
		(s_axi_araddr == ptws_pkg::STATUS_OFFSET) ||
		(s_axi_araddr == ptws_pkg::INT_MASK_OFFSET);
	wire logic [31:0] rdMux =
		(s_axi_araddr == ptws_pkg::IO_SIZE_OFFSET) ? ioSize :
		(s_axi_araddr == ptws_pkg::MEM_SIZE_OFFSET) ? memSize :
		(s_axi_araddr == ptws_pkg::STATUS_OFFSET) ? status :
		(s_axi_araddr == ptws_pkg::INT_MASK_OFFSET) ? intMask : 32'h00000000;

	// set wins over the clear-on-read in the same cycle
	wire logic [31:0] next_status = sizeBad ? (status | FLAG_MASK) :
		(rdStatus ? 32'h00000000 : status);

	always_ff @(posedge clk or negedge rstLocal_n) begin
		if (!rstLocal_n) begin
			awHeld <= 1'b0;
			wHeld <= 1'b0;
			awAddr <= 32'h00000000;
			wData <= 32'h00000000;
			wStrb <= 4'h0;
		end else begin
			if (doWrite) begin
				awHeld <= 1'b0;
				wHeld <= 1'b0;
			end else begin
				if (awTake) begin
					awHeld <= 1'b1;
					awAddr <= s_axi_awaddr;
				end
				if (wTake) begin
					wHeld <= 1'b1;
					wData <= s_axi_wdata;
					wStrb <= s_axi_wstrb;
				end
			end
		end
	end

	always_ff @(posedge clk or negedge rstLocal_n) begin
		if (!rstLocal_n) begin
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= ptws_pkg::RESP_OKAY;
		end else begin
			s_axi_awready <= !haveAw && !s_axi_bvalid;
			s_axi_wready <= !haveW && !s_axi_bvalid;
			if (doWrite) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wrHit ? ptws_pkg::RESP_OKAY : ptws_pkg::RESP_SLVERR;
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk or negedge rstLocal_n) begin
		if (!rstLocal_n) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= ptws_pkg::RESP_OKAY;
		end else begin
			s_axi_arready <= !s_axi_rvalid && !arTake;
			if (arTake) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata <= rdMux;
				s_axi_rresp <= rdHit ? ptws_pkg::RESP_OKAY : ptws_pkg::RESP_SLVERR;
			end else if (s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk or negedge rstLocal_n) begin
		if (!rstLocal_n) begin
			ioSize <= ptws_pkg::IO_SIZE_RESET;
			memSize <= ptws_pkg::MEM_SIZE_RESET;
			status <= ptws_pkg::STATUS_RESET;
			intMask <= ptws_pkg::INT_MASK_RESET;
		end else begin
			if (wrIo) begin
				ioSize <= next_ioSize;
			end
			if (wrMem) begin
				memSize <= next_memSize;
			end
			if (wrMask) begin
				intMask <= next_intMask;
			end
			status <= next_status;
		end
	end

	// size masks applied to base and map addresses; outside writers order their writes
	wire logic [31:0] ioBaseM;
	wire logic [31:0] ioMapM;
	wire logic [31:0] memBaseM;
	wire logic [31:0] memMapM;
	ptws_base_mask ioMask (
		.sizeValue(ioSize),
		.baseWritten(ioBaseAddr),
		.mapWritten(ioLocalMapAddr),
		.baseMasked(ioBaseM),
		.mapMasked(ioMapM)
	);
	ptws_base_mask memMask (
		.sizeValue(memSize),
		.baseWritten(memBaseAddr),
		.mapWritten(memLocalMapAddr),
		.baseMasked(memBaseM),
		.mapMasked(memMapM)
	);

	// outputs registered; one cycle behind the inputs and the size registers
	always_ff @(posedge clk or negedge rstLocal_n) begin
		if (!rstLocal_n) begin
			ioBaseReadback <= 32'h00000000;
			ioLocalMapMasked <= 32'h00000000;
			memBaseReadback <= 32'h00000000;
			memLocalMapMasked <= 32'h00000000;
			ioWindowEnable <= 1'b0;
			memWindowEnable <= 1'b0;
			irq <= 1'b0;
		end else begin
			ioBaseReadback <= ioBaseM;
			ioLocalMapMasked <= ioMapM;
			memBaseReadback <= memBaseM;
			memLocalMapMasked <= memMapM;
			ioWindowEnable <= (ioSize != 32'h00000000);
			memWindowEnable <= (memSize != 32'h00000000);
			irq <= |(next_status & intMask);
		end
	end

	a_flag_on_bad: assert property (@(posedge clk) disable iff (!rstLocal_n)
		sizeBad |=> status[ptws_pkg::ILLEGAL_SIZE_BIT])
		else $error("illegal size write did not set the flag");
	a_io_disable: assert property (@(posedge clk) disable iff (!rstLocal_n)
		(ioSize == 32'h00000000) |=> !ioWindowEnable)
		else $error("io window enabled with zero size");
	a_mem_disable: assert property (@(posedge clk) disable iff (!rstLocal_n)
		(memSize == 32'h00000000) |=> !memWindowEnable)
		else $error("memory window enabled with zero size");
	a_io_mask: assert property (@(posedge clk) disable iff (!rstLocal_n)
		rstLocal_n |=> ioBaseReadback == ($past(ioBaseAddr) & $past(ioSize)))
		else $error("io base readback not masked by io size");
	a_mem_mask: assert property (@(posedge clk) disable iff (!rstLocal_n)
		rstLocal_n |=> memBaseReadback == ($past(memBaseAddr) & $past(memSize)))
		else $error("memory base readback not masked by memory size");
	a_io_field: assert property (@(posedge clk) disable iff (!rstLocal_n)
		ioSize[1:0] == 2'h0)
		else $error("io size low bits not zero");
	a_mem_field: assert property (@(posedge clk) disable iff (!rstLocal_n)
		memSize[3:0] == 4'h0)
		else $error("memory size low bits not zero");
	a_irq_gate: assert property (@(posedge clk) disable iff (!rstLocal_n)
		(status[ptws_pkg::ILLEGAL_SIZE_BIT] && intMask[ptws_pkg::ILLEGAL_SIZE_BIT]
		&& !rdStatus) |=> irq)
		else $error("masked-in flag did not raise the interrupt");
	a_good_no_flag: assert property (@(posedge clk) disable iff (!rstLocal_n)
		(rdStatus && !sizeBad) |=> !status[ptws_pkg::ILLEGAL_SIZE_BIT])
		else $error("status not cleared by read");
	// sampled release gates the first edge, where the output flops still sit in reset
	a_io_enable: assert property (@(posedge clk) disable iff (!rstLocal_n)
		(rstLocal_n && (ioSize != 32'h00000000)) |=> ioWindowEnable)
		else $error("io window not enabled with nonzero size");
	a_mem_enable: assert property (@(posedge clk) disable iff (!rstLocal_n)
		(rstLocal_n && (memSize != 32'h00000000)) |=> memWindowEnable)
		else $error("memory window not enabled with nonzero size");
	a_io_map: assert property (@(posedge clk) disable iff (!rstLocal_n)
		rstLocal_n |=> ioLocalMapMasked == ($past(ioLocalMapAddr) & $past(ioSize)))
		else $error("io local map not masked by io size");
	a_mem_map: assert property (@(posedge clk) disable iff (!rstLocal_n)
		rstLocal_n |=> memLocalMapMasked == ($past(memLocalMapAddr) & $past(memSize)))
		else $error("memory local map not masked by memory size");
	a_io_reset: assert property (@(posedge clk) disable iff (!rstLocal_n)
		$rose(rstLocal_n) |-> (ioSize == ptws_pkg::IO_SIZE_RESET))
		else $error("io size wrong after reset");
	a_mem_reset: assert property (@(posedge clk) disable iff (!rstLocal_n)
		$rose(rstLocal_n) |-> (memSize == ptws_pkg::MEM_SIZE_RESET))
		else $error("memory size wrong after reset");
	a_status_reset: assert property (@(posedge clk) disable iff (!rstLocal_n)
		$rose(rstLocal_n) |-> !status[ptws_pkg::ILLEGAL_SIZE_BIT])
		else $error("illegal-size flag set after reset");
	a_io_legal_quiet: assert property (@(posedge clk) disable iff (!rstLocal_n)
		(wrIo && ioNewLegal && !status[ptws_pkg::ILLEGAL_SIZE_BIT])
		|=> !status[ptws_pkg::ILLEGAL_SIZE_BIT])
		else $error("legal io size set the flag");
	a_mem_legal_quiet: assert property (@(posedge clk) disable iff (!rstLocal_n)
		(wrMem && memNewLegal && !status[ptws_pkg::ILLEGAL_SIZE_BIT])
		|=> !status[ptws_pkg::ILLEGAL_SIZE_BIT])
		else $error("legal memory size set the flag");
	a_io_write_lands: assert property (@(posedge clk) disable iff (!rstLocal_n)
		(wrIo && (curWStrb == 4'hf)) |=> ioSize == ($past(curWData) & IO_FIELD))
		else $error("io size write did not land in the field");
	a_mem_write_lands: assert property (@(posedge clk) disable iff (!rstLocal_n)
		(wrMem && (curWStrb == 4'hf)) |=> memSize == ($past(curWData) & MEM_FIELD))
		else $error("memory size write did not land in the field");
	a_irq_quiet: assert property (@(posedge clk) disable iff (!rstLocal_n)
		(!status[ptws_pkg::ILLEGAL_SIZE_BIT] && !sizeBad) |=> !irq)
		else $error("interrupt raised with no flag");
	a_bvalid_hold: assert property (@(posedge clk) disable iff (!rstLocal_n)
		(s_axi_bvalid && !s_axi_bready) |=> (s_axi_bvalid && $stable(s_axi_bresp)))
		else $error("write response dropped before it was taken");
	a_rvalid_hold: assert property (@(posedge clk) disable iff (!rstLocal_n)
		(s_axi_rvalid && !s_axi_rready) |=> (s_axi_rvalid && $stable(s_axi_rdata)))
		else $error("read data dropped before it was taken");
	a_aw_refused: assert property (@(posedge clk) disable iff (!rstLocal_n)
		s_axi_bvalid |-> (!s_axi_awready && !s_axi_wready))
		else $error("write accepted while a response is pending");
	a_ar_refused: assert property (@(posedge clk) disable iff (!rstLocal_n)
		s_axi_rvalid |-> !s_axi_arready)
		else $error("read accepted while read data is pending");
endmodule : ptws_window_sizer
`default_nettype wire

/* File: tb/ptws_pci_master.sv */
// pci master model: drives the base and local map values that the sizer masks
// the bench raises sizing right after the reset reads, before either size register is written
`timescale 1ns/1ps
`default_nettype none
module ptws_pci_master #(
	parameter logic [31:0] MAP_PATTERN = 32'h5a5a5a5a
) (
	input wire logic clk,
	input wire logic sizing,
	output logic [31:0] ioBase,
	output logic [31:0] ioMap,
	output logic [31:0] memBase,
	output logic [31:0] memMap
);
	// sizing writes all ones to both base registers, otherwise a fixed pattern
	always_ff @(posedge clk) begin
		ioBase <= sizing ? 32'hffffffff : MAP_PATTERN;
		memBase <= sizing ? 32'hffffffff : MAP_PATTERN;
		ioMap <= MAP_PATTERN;
		memMap <= ~MAP_PATTERN;
	end
endmodule : ptws_pci_master
`default_nettype wire

/* File: tb/test_ptws_window_sizer.sv */
// bench for the target window sizer: axi4-lite register tests and base sizing views
// assumes one 200 MHz clock and the pci master model beside the design
`timescale 1ns/1ps
`default_nettype none
module test_ptws_window_sizer;
	localparam logic [31:0] MAP = 32'h5a5a5a5a;
	logic clk, rst_n = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
	logic arvalid = 1'b0, rready = 1'b0, sizing = 1'b0;
	logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0, v;
	logic [3:0] wstrb = 4'hf;
	logic [31:0] ioB, ioM, memB, memM, ioBr, ioMm, memBr, memMm, rdata;
	logic [1:0] bresp, rresp, resp;
	logic awready, wready, bvalid, arready, rvalid, ioEn, memEn, irq;
	int error_cnt = 0;
	int cmp_count = 0;
	logic [31:0] ioLegal [5] = '{32'hfffffffc, 32'hfffffff0, 32'hfe000000, 32'hc0000000,
		32'h80000000};
	logic [31:0] memLegal [3] = '{32'hfffffff0, 32'hfe000000, 32'hc0000000};
	ptws_window_sizer uut (.clk(clk), .rst_n(rst_n), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .ioBaseAddr(ioB), .ioLocalMapAddr(ioM), .memBaseAddr(memB),
		.memLocalMapAddr(memM), .ioBaseReadback(ioBr), .ioLocalMapMasked(ioMm),
		.memBaseReadback(memBr), .memLocalMapMasked(memMm), .ioWindowEnable(ioEn),
		.memWindowEnable(memEn), .irq(irq));
	ptws_pci_master #(.MAP_PATTERN(MAP)) pci (.clk(clk), .sizing(sizing), .ioBase(ioB),
		.ioMap(ioM), .memBase(memB), .memMap(memM));
	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			error_cnt++;
			$display("mismatch %s expected %h seen %h", name, exp, seen);
		end
	endtask : check
	// valid and payload held until the edge that samples ready high
	task automatic axi_write(input logic [31:0] addr, input logic [31:0] data);
		logic ta, tw, tb;
		@(posedge clk);
		awaddr <= addr;
		wdata <= data;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		forever begin
			#1;
			ta = awvalid && awready;
			tw = wvalid && wready;
			tb = bvalid;
			resp = bresp;
			@(posedge clk);
			if (ta) awvalid <= 1'b0;
			if (tw) wvalid <= 1'b0;
			if (tb) begin
				bready <= 1'b0;
				break;
			end
		end
	endtask : axi_write
	task automatic axi_read(input logic [31:0] addr);
		logic ta, tr;
		@(posedge clk);
		araddr <= addr;
		arvalid <= 1'b1;
		rready <= 1'b1;
		forever begin
			#1;
			ta = arvalid && arready;
			tr = rvalid;
			v = rdata;
			resp = rresp;
			@(posedge clk);
			if (ta) arvalid <= 1'b0;
			if (tr) begin
				rready <= 1'b0;
				break;
			end
		end
	endtask : axi_read
	task automatic settle;
		repeat (2) @(posedge clk);
		#1;
	endtask : settle
	task automatic final_report;
		if (error_cnt == 0 && cmp_count > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : final_report
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	// generous: the whole sequence needs well under a thousand cycles
	initial begin
		repeat (4000) @(posedge clk);
		error_cnt++;
		final_report();
	end
	initial begin
		repeat (20) @(posedge clk);
		rst_n <= 1'b1;
		repeat (4) @(posedge clk);
		axi_read(ptws_pkg::IO_SIZE_OFFSET);
		check("io size reset", v, ptws_pkg::IO_SIZE_RESET);
		axi_read(ptws_pkg::MEM_SIZE_OFFSET);
		check("mem size reset", v, ptws_pkg::MEM_SIZE_RESET);
		axi_read(ptws_pkg::STATUS_OFFSET);
		check("status reset", v, ptws_pkg::STATUS_RESET);
		axi_read(ptws_pkg::INT_MASK_OFFSET);
		check("mask reset", v, ptws_pkg::INT_MASK_RESET);
		check("windows on", {30'h0, ioEn, memEn}, 32'h3);
		sizing <= 1'b1;
		settle();
		check("io sizing reset", ioBr, ptws_pkg::IO_SIZE_RESET);
		check("mem sizing reset", memBr, ptws_pkg::MEM_SIZE_RESET);
		foreach (ioLegal[i]) begin
			axi_write(ptws_pkg::IO_SIZE_OFFSET, ioLegal[i]);
			check("write resp", {30'h0, resp}, {30'h0, ptws_pkg::RESP_OKAY});
			axi_read(ptws_pkg::IO_SIZE_OFFSET);
			check("io size", v, ioLegal[i]);
			check("io base sizing", ioBr, ioLegal[i]);
			check("io map masked", ioMm, MAP & ioLegal[i]);
		end
		foreach (memLegal[i]) begin
			axi_write(ptws_pkg::MEM_SIZE_OFFSET, memLegal[i]);
			axi_read(ptws_pkg::MEM_SIZE_OFFSET);
			check("mem size", v, memLegal[i]);
			check("mem base sizing", memBr, memLegal[i]);
			check("mem map masked", memMm, ~MAP & memLegal[i]);
		end
		axi_read(ptws_pkg::STATUS_OFFSET);
		check("status legal", v, 32'h0);
		sizing <= 1'b0;
		settle();
		check("io base masked", ioBr, MAP & 32'h80000000);
		axi_write(ptws_pkg::IO_SIZE_OFFSET, 32'h0);
		axi_write(ptws_pkg::MEM_SIZE_OFFSET, 32'h0);
		settle();
		check("io window off", {31'h0, ioEn}, 32'h0);
		check("mem window off", {31'h0, memEn}, 32'h0);
		axi_write(ptws_pkg::INT_MASK_OFFSET, 32'h4);
		axi_write(ptws_pkg::IO_SIZE_OFFSET, 32'hff00ff00);
		axi_read(ptws_pkg::STATUS_OFFSET);
		check("status io bad", v, 32'h4);
		settle();
		check("irq cleared", {31'h0, irq}, 32'h0);
		axi_write(ptws_pkg::MEM_SIZE_OFFSET, 32'ha0000000);
		settle();
		check("irq raised", {31'h0, irq}, 32'h1);
		axi_write(ptws_pkg::INT_MASK_OFFSET, 32'h0);
		settle();
		check("irq masked", {31'h0, irq}, 32'h0);
		axi_read(ptws_pkg::STATUS_OFFSET);
		check("status mem bad", v, 32'h4);
		axi_read(ptws_pkg::STATUS_OFFSET);
		check("status clear", v, 32'h0);
		axi_write(32'hfffed200, 32'h1);
		check("unmapped write", {30'h0, resp}, {30'h0, ptws_pkg::RESP_SLVERR});
		axi_read(32'hfffed200);
		check("unmapped read", {30'h0, resp}, {30'h0, ptws_pkg::RESP_SLVERR});
		final_report();
	end
endmodule : test_ptws_window_sizer
`default_nettype wire
